// ==== hdl/imlru_pkg.sv ====
package imlru_pkg;

  localparam int unsigned XLEN = 32;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned GPR_IDX_W = 5;

  // Little-endian indices of the architecturally numbered bits 16..31
  localparam int unsigned MSR_LOW_W = 16;
  localparam int unsigned MSR_EE_BIT = 15;
  localparam int unsigned MSR_PR_BIT = 14;
  localparam logic [31:0] MSR_RST = 32'h0000_0000;
  localparam logic [31:0] SAVED_RETURN_ADDRESS_RST = 32'h0000_0000;
  localparam logic [31:0] SAVED_MACHINE_STATE_RST = 32'h0000_0000;
  localparam logic [1:0] FETCH_ALIGN = 2'h0;

  localparam logic [31:0] MOST_NEG = 32'h8000_0000;
  localparam logic [15:0] NOP_IMM = 16'h0000;
  localparam logic [4:0] NOP_GPR = 5'h00;

  // Condition field zero layout
  localparam int unsigned CR_LT_BIT = 3;
  localparam int unsigned CR_GT_BIT = 2;
  localparam int unsigned CR_EQ_BIT = 1;
  localparam int unsigned CR_SO_BIT = 0;

  typedef enum logic [3:0] {
    OP_MUL_LOW_IMM,
    OP_MUL_LOW_WORD,
    OP_NOT_AND,
    OP_TWOS_COMPLEMENT,
    OP_NOT_OR,
    OP_OR_REG,
    OP_OR_INVERTED,
    OP_OR_IMM,
    OP_OR_UPPER_IMM,
    OP_RETURN_FROM_INTERRUPT
  } imlru_op_t;

  typedef struct packed {
    imlru_op_t op;
    logic [31:0] source_a_gpr;
    logic [31:0] source_b_gpr;
    logic [31:0] source_s_gpr;
    logic [4:0] source_s_idx;
    logic [4:0] dest_idx;
    logic [15:0] imm;
    logic overflow_enable_bit;
    logic record_bit;
  } imlru_issue_t;

  typedef struct packed {
    logic en;
    logic [4:0] dest_idx;
    logic [31:0] data;
  } imlru_wb_t;

endpackage : imlru_pkg

// ==== hdl/imlru_mul.sv ====
`timescale 1ns/100ps
`default_nettype none
module imlru_mul #(
  parameter int unsigned W = 32
) (
  input wire logic [W-1:0] op_a_i,
  input wire logic [W-1:0] op_b_i,
  output logic [W-1:0] prod_low_o,
  output logic ovf_o
);

  logic signed [2*W-1:0] prod;

  if (W < 2) begin : g_bad_width
    $error("imlru_mul: width too small");
  end

  // Signed product; the low half is the same for unsigned operands
  assign prod = $signed(op_a_i) * $signed(op_b_i);
  assign prod_low_o = prod[W-1:0];
  // Does not fit when the high half is not the sign extension of the low half
  assign ovf_o = (prod[2*W-1:W] != {W{prod[W-1]}});

endmodule : imlru_mul
`default_nettype wire

// ==== hdl/imlru_unit.sv ====
// What this block does
// - Immediate multiply-low writes low 32 bits of operand times sign-extended immediate.
// - Low product bits are identical for signed and unsigned operand views.
// - Word multiply-low writes low 32 bits of the 64-bit product.
// - With overflow enable, word multiply sets overflow when signed product exceeds 32 bits.
// - Overflow enable on word multiply or negate updates overflow and sticky summary overflow flags.
// - Record bit updates less, greater, equal and summary flags from result.
// - NAND of s and b operands written to destination.
// - Negate writes inverted operand plus one; most negative value overflows.
// - NOR of s and b operands written to destination.
// - OR of s and b operands written to destination.
// - OR of s with inverted b written to destination.
// - OR of s with zero-extended immediate written to destination.
// - OR of s with immediate shifted to upper half written to destination.
// - Immediate OR of register zero with zero is a no-op.
// - Return copies saved state low half into machine state low half.
// - Without enabled pending exception, fetch redirects to saved address, word aligned.
// - With enabled pending exception, take highest priority, saving next address.
// - Return only in supervisor mode, after all prior instructions complete.
`timescale 1ns/100ps
`default_nettype none
module imlru_unit #(
  parameter int unsigned NUM_EXC = 4
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  input wire imlru_pkg::imlru_issue_t issue_i,
  output logic issue_ready_o,
  input wire logic pipe_empty_i,
  input wire logic [NUM_EXC-1:0] pending_exc_i,
  input wire logic xer_clear_i,
  input wire logic msr_we_i,
  input wire logic saved_return_address_we_i,
  input wire logic saved_machine_state_we_i,
  input wire logic [31:0] state_wdata_i,
  output imlru_pkg::imlru_wb_t wb_o,
  output logic [3:0] cr0_o,
  output logic cr0_we_o,
  output logic summary_overflow_o,
  output logic overflow_o,
  output logic [31:0] msr_o,
  output logic [31:0] saved_return_address_o,
  output logic [31:0] saved_machine_state_o,
  output logic redirect_o,
  output logic [31:0] fetch_addr_o,
  output logic exc_take_o,
  output logic [$clog2(NUM_EXC+1)-1:0] exc_idx_o,
  output logic priv_exc_o
);

  localparam int unsigned IDX_W = $clog2(NUM_EXC+1);

  if (NUM_EXC < 1 || NUM_EXC > 32) begin : g_bad_num_exc
    $error("imlru_unit: NUM_EXC out of range");
  end

  typedef enum logic {
    ST_IDLE,
    ST_SYNC
  } imlru_state_t;

  imlru_state_t state_ff, nxt_state;
  imlru_pkg::imlru_wb_t wb_ff, nxt_wb;
  logic [3:0] cr0_ff, nxt_cr0;
  logic cr0_we_ff, nxt_cr0_we;
  logic so_ff, nxt_so;
  logic ov_ff, nxt_ov;
  logic [31:0] msr_ff, nxt_msr;
  logic [31:0] saved_return_address_ff, nxt_saved_return_address;
  logic [31:0] saved_machine_state_ff, nxt_saved_machine_state;
  logic redirect_ff, nxt_redirect;
  logic [31:0] fetch_addr_ff, nxt_fetch_addr;
  logic exc_take_ff, nxt_exc_take;
  logic [IDX_W-1:0] exc_idx_ff, nxt_exc_idx;
  logic priv_exc_ff, nxt_priv_exc;

  logic fire;
  logic is_rfi;
  logic user_mode;
  logic rfi_go;
  logic [31:0] mul_b;
  logic [31:0] mul_low;
  logic mul_ovf;
  logic [31:0] alu_res;
  logic alu_ovf;
  logic ovf_capable;
  logic is_nop;
  logic [31:0] restored_msr;
  logic [NUM_EXC-1:0] enabled_exc;
  logic [31:0] return_addr;

  assign issue_ready_o = (state_ff == ST_IDLE);
  assign fire = issue_valid_i && issue_ready_o;
  assign is_rfi = (issue_i.op == imlru_pkg::OP_RETURN_FROM_INTERRUPT);
  assign user_mode = msr_ff[imlru_pkg::MSR_PR_BIT];

  // Immediate multiply shares the word multiplier; its 48-bit product has the same low word
  assign mul_b = (issue_i.op == imlru_pkg::OP_MUL_LOW_IMM) ?
                 {{(imlru_pkg::XLEN-imlru_pkg::IMM_W){issue_i.imm[15]}}, issue_i.imm} :
                 issue_i.source_b_gpr;

  imlru_mul #(
    .W(imlru_pkg::XLEN)
  ) u_mul (
    .op_a_i(issue_i.source_a_gpr),
    .op_b_i(mul_b),
    .prod_low_o(mul_low),
    .ovf_o(mul_ovf)
  );

  always_comb begin
    alu_res = 32'h0000_0000;
    alu_ovf = 1'b0;
    ovf_capable = 1'b0;
    unique case (issue_i.op)
      imlru_pkg::OP_MUL_LOW_IMM: alu_res = mul_low;
      imlru_pkg::OP_MUL_LOW_WORD: begin
        alu_res = mul_low;
        alu_ovf = mul_ovf;
        ovf_capable = 1'b1;
      end
      imlru_pkg::OP_NOT_AND: alu_res = ~(issue_i.source_s_gpr & issue_i.source_b_gpr);
      imlru_pkg::OP_TWOS_COMPLEMENT: begin
        alu_res = ~issue_i.source_a_gpr + 32'h0000_0001;
        alu_ovf = (issue_i.source_a_gpr == imlru_pkg::MOST_NEG);
        ovf_capable = 1'b1;
      end
      imlru_pkg::OP_NOT_OR: alu_res = ~(issue_i.source_s_gpr | issue_i.source_b_gpr);
      imlru_pkg::OP_OR_REG: alu_res = issue_i.source_s_gpr | issue_i.source_b_gpr;
      imlru_pkg::OP_OR_INVERTED: alu_res = issue_i.source_s_gpr | ~issue_i.source_b_gpr;
      imlru_pkg::OP_OR_IMM: alu_res = issue_i.source_s_gpr | {16'h0000, issue_i.imm};
      imlru_pkg::OP_OR_UPPER_IMM: alu_res = issue_i.source_s_gpr | {issue_i.imm, 16'h0000};
      default: alu_res = 32'h0000_0000;
    endcase
  end

  assign is_nop = (issue_i.op == imlru_pkg::OP_OR_IMM) && (issue_i.imm == imlru_pkg::NOP_IMM) &&
                  (issue_i.dest_idx == imlru_pkg::NOP_GPR) &&
                  (issue_i.source_s_idx == imlru_pkg::NOP_GPR);

  assign restored_msr = {msr_ff[31:imlru_pkg::MSR_LOW_W],
                         saved_machine_state_ff[imlru_pkg::MSR_LOW_W-1:0]};
  assign enabled_exc = pending_exc_i & {NUM_EXC{restored_msr[imlru_pkg::MSR_EE_BIT]}};
  assign return_addr = {saved_return_address_ff[31:2], imlru_pkg::FETCH_ALIGN};
  // Prior instructions must have drained before the context changes
  assign rfi_go = pipe_empty_i && ((state_ff == ST_SYNC) ||
                  (fire && is_rfi && !user_mode));

  always_comb begin
    nxt_state = state_ff;
    nxt_wb = '0;
    nxt_cr0 = cr0_ff;
    nxt_cr0_we = 1'b0;
    nxt_so = so_ff && !xer_clear_i;
    nxt_ov = ov_ff && !xer_clear_i;
    nxt_msr = msr_we_i ? state_wdata_i : msr_ff;
    nxt_saved_return_address = saved_return_address_we_i ? state_wdata_i : saved_return_address_ff;
    nxt_saved_machine_state = saved_machine_state_we_i ? state_wdata_i : saved_machine_state_ff;
    nxt_redirect = 1'b0;
    nxt_fetch_addr = fetch_addr_ff;
    nxt_exc_take = 1'b0;
    nxt_exc_idx = exc_idx_ff;
    nxt_priv_exc = 1'b0;
    if (fire && !is_rfi) begin
      nxt_wb.en = !is_nop;
      nxt_wb.dest_idx = issue_i.dest_idx;
      nxt_wb.data = alu_res;
      if (issue_i.overflow_enable_bit && ovf_capable) begin
        // Hardware set wins over a simultaneous software clear
        nxt_ov = alu_ovf;
        nxt_so = nxt_so || alu_ovf;
      end
      if (issue_i.record_bit) begin
        nxt_cr0_we = 1'b1;
        nxt_cr0[imlru_pkg::CR_LT_BIT] = alu_res[31];
        nxt_cr0[imlru_pkg::CR_GT_BIT] = !alu_res[31] && (alu_res != 32'h0000_0000);
        nxt_cr0[imlru_pkg::CR_EQ_BIT] = (alu_res == 32'h0000_0000);
        nxt_cr0[imlru_pkg::CR_SO_BIT] = nxt_so;
      end
    end
    if (fire && is_rfi && user_mode) begin
      nxt_priv_exc = 1'b1;
    end else if (fire && is_rfi && !pipe_empty_i) begin
      nxt_state = ST_SYNC;
    end
    if (rfi_go) begin
      nxt_state = ST_IDLE;
      nxt_msr = restored_msr;
      if (|enabled_exc) begin
        nxt_exc_take = 1'b1;
        nxt_saved_return_address = return_addr;
        nxt_exc_idx = '0;
        // Lowest index carries the highest priority
        for (int i = NUM_EXC-1; i >= 0; i--) begin
          if (enabled_exc[i]) begin
            nxt_exc_idx = IDX_W'(i);
          end
        end
      end else begin
        nxt_redirect = 1'b1;
        nxt_fetch_addr = return_addr;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_IDLE;
      wb_ff <= '0;
      cr0_ff <= 4'h0;
      cr0_we_ff <= 1'b0;
      so_ff <= 1'b0;
      ov_ff <= 1'b0;
      msr_ff <= imlru_pkg::MSR_RST;
      saved_return_address_ff <= imlru_pkg::SAVED_RETURN_ADDRESS_RST;
      saved_machine_state_ff <= imlru_pkg::SAVED_MACHINE_STATE_RST;
      redirect_ff <= 1'b0;
      fetch_addr_ff <= 32'h0000_0000;
      exc_take_ff <= 1'b0;
      exc_idx_ff <= '0;
      priv_exc_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wb_ff <= nxt_wb;
      cr0_ff <= nxt_cr0;
      cr0_we_ff <= nxt_cr0_we;
      so_ff <= nxt_so;
      ov_ff <= nxt_ov;
      msr_ff <= nxt_msr;
      saved_return_address_ff <= nxt_saved_return_address;
      saved_machine_state_ff <= nxt_saved_machine_state;
      redirect_ff <= nxt_redirect;
      fetch_addr_ff <= nxt_fetch_addr;
      exc_take_ff <= nxt_exc_take;
      exc_idx_ff <= nxt_exc_idx;
      priv_exc_ff <= nxt_priv_exc;
    end
  end

  assign wb_o = wb_ff;
  assign cr0_o = cr0_ff;
  assign cr0_we_o = cr0_we_ff;
  assign summary_overflow_o = so_ff;
  assign overflow_o = ov_ff;
  assign msr_o = msr_ff;
  assign saved_return_address_o = saved_return_address_ff;
  assign saved_machine_state_o = saved_machine_state_ff;
  assign redirect_o = redirect_ff;
  assign fetch_addr_o = fetch_addr_ff;
  assign exc_take_o = exc_take_ff;
  assign exc_idx_o = exc_idx_ff;
  assign priv_exc_o = priv_exc_ff;

  // Checks
  logic [63:0] ref_word_prod;
  logic [31:0] ref_imm_prod;
  assign ref_word_prod = issue_i.source_a_gpr * issue_i.source_b_gpr;
  assign ref_imm_prod = 32'(issue_i.source_a_gpr * {{16{issue_i.imm[15]}}, issue_i.imm});

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_alu_fire(imlru_pkg::imlru_op_t o);
    fire && issue_i.op == o;
  endsequence

  property p_mul_word;
    logic [31:0] exp;
    (s_alu_fire(imlru_pkg::OP_MUL_LOW_WORD), exp = ref_word_prod[31:0]) |=> wb_o.en && wb_o.data == exp;
  endproperty
  a_mul_word: assert property (p_mul_word) else $error("word multiply low result wrong");
  property p_mul_imm;
    logic [31:0] exp;
    (s_alu_fire(imlru_pkg::OP_MUL_LOW_IMM), exp = ref_imm_prod) |=> wb_o.data == exp;
  endproperty
  a_mul_imm: assert property (p_mul_imm) else $error("immediate multiply low result wrong");
  property p_nand;
    s_alu_fire(imlru_pkg::OP_NOT_AND) |=>
      wb_o.data == ~($past(issue_i.source_s_gpr) & $past(issue_i.source_b_gpr));
  endproperty
  a_nand: assert property (p_nand) else $error("nand result wrong");
  property p_neg_min;
    s_alu_fire(imlru_pkg::OP_TWOS_COMPLEMENT) ##0
      (issue_i.source_a_gpr == imlru_pkg::MOST_NEG && issue_i.overflow_enable_bit) |=>
      wb_o.data == imlru_pkg::MOST_NEG && overflow_o && summary_overflow_o;
  endproperty
  a_neg_min: assert property (p_neg_min) else $error("negate of most negative value wrong");
  property p_so_sticky;
    overflow_o && !$past(overflow_o) |-> summary_overflow_o;
  endproperty
  a_so_sticky: assert property (p_so_sticky) else $error("summary overflow not set with overflow");
  property p_cr0;
    cr0_we_o |-> cr0_o[imlru_pkg::CR_EQ_BIT] == (wb_o.data == 32'h0000_0000) &&
      cr0_o[imlru_pkg::CR_LT_BIT] == wb_o.data[31] && cr0_o[imlru_pkg::CR_SO_BIT] == summary_overflow_o;
  endproperty
  a_cr0: assert property (p_cr0) else $error("condition field mismatch");
  property p_nop;
    fire && is_nop |=> !wb_o.en && !cr0_we_o;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op had an effect");
  property p_rfi_user;
    fire && is_rfi && user_mode |=> priv_exc_o && $stable(msr_o) && !redirect_o && !exc_take_o;
  endproperty
  a_rfi_user: assert property (p_rfi_user) else $error("user return not refused");
  sequence s_rfi_wait;
    state_ff == ST_SYNC && !pipe_empty_i;
  endsequence
  property p_rfi_hold;
    s_rfi_wait |=> !redirect_o && !exc_take_o && $stable(msr_o);
  endproperty
  a_rfi_hold: assert property (p_rfi_hold) else $error("return acted before pipeline drained");
  sequence s_rfi_clean;
    rfi_go && enabled_exc == '0;
  endsequence
  property p_rfi_redirect;
    logic [31:0] addr;
    (s_rfi_clean, addr = return_addr) |=> redirect_o && fetch_addr_o == addr && fetch_addr_o[1:0] == 2'h0;
  endproperty
  a_rfi_redirect: assert property (p_rfi_redirect) else $error("return redirect wrong");
  property p_rfi_exc;
    rfi_go && |enabled_exc |=> exc_take_o && !redirect_o && saved_return_address_o == $past(return_addr);
  endproperty
  a_rfi_exc: assert property (p_rfi_exc) else $error("pending exception not taken on return");
  property p_rfi_msr;
    rfi_go && !msr_we_i |=> msr_o[15:0] == $past(saved_machine_state_o[15:0]);
  endproperty
  a_rfi_msr: assert property (p_rfi_msr) else $error("machine state low half not restored");

endmodule : imlru_unit
`default_nettype wire

// ==== verification/imlru_disp_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module imlru_disp_model (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire imlru_pkg::imlru_wb_t wb_i,
  input wire logic drain_load_i,
  input wire logic [3:0] drain_len_i,
  output logic pipe_empty_o
);
  logic [31:0] gpr_ff [32];
  logic [3:0] busy_ff;

  // Older work still in flight keeps the drain flag low, so returns can be made to wait
  assign pipe_empty_o = (busy_ff == 4'h0);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      busy_ff <= 4'h0;
    end else if (drain_load_i) begin
      busy_ff <= drain_len_i;
    end else if (busy_ff != 4'h0) begin
      busy_ff <= busy_ff - 4'h1;
    end
    if (wb_i.en) begin
      gpr_ff[wb_i.dest_idx] <= wb_i.data;
    end
  end
endmodule : imlru_disp_model
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic issue_valid_i = 1'b0;
  imlru_pkg::imlru_issue_t issue_i = '0;
  logic pipe_empty_i;
  logic [3:0] pending_exc_i = 4'h0;
  logic xer_clear_i = 1'b0;
  logic msr_we_i = 1'b0;
  logic saved_return_address_we_i = 1'b0;
  logic saved_machine_state_we_i = 1'b0;
  logic [31:0] state_wdata_i = 32'h0;
  logic drain_load = 1'b0;
  logic [3:0] drain_len = 4'h0;
  logic issue_ready_o, cr0_we_o, summary_overflow_o, overflow_o, redirect_o, exc_take_o, priv_exc_o;
  imlru_pkg::imlru_wb_t wb_o;
  logic [3:0] cr0_o;
  logic [31:0] msr_o, saved_return_address_o, saved_machine_state_o, fetch_addr_o;
  logic [2:0] exc_idx_o;
  int miscompares = 0;
  int cmp_count = 0;
  logic ov_m = 1'b0;
  logic so_m = 1'b0;
  logic pend = 1'b0;
  logic [4:0] pd = 5'h0;
  logic [31:0] pv = 32'h0;
  imlru_pkg::imlru_issue_t u;

  imlru_unit #(.NUM_EXC(4)) imlru_unit_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .issue_valid_i(issue_valid_i), .issue_i(issue_i), .issue_ready_o(issue_ready_o),
    .pipe_empty_i(pipe_empty_i), .pending_exc_i(pending_exc_i), .xer_clear_i(xer_clear_i),
    .msr_we_i(msr_we_i), .saved_return_address_we_i(saved_return_address_we_i), .saved_machine_state_we_i(saved_machine_state_we_i), .state_wdata_i(state_wdata_i),
    .wb_o(wb_o), .cr0_o(cr0_o), .cr0_we_o(cr0_we_o), .summary_overflow_o(summary_overflow_o),
    .overflow_o(overflow_o), .msr_o(msr_o), .saved_return_address_o(saved_return_address_o), .saved_machine_state_o(saved_machine_state_o), .redirect_o(redirect_o),
    .fetch_addr_o(fetch_addr_o), .exc_take_o(exc_take_o), .exc_idx_o(exc_idx_o), .priv_exc_o(priv_exc_o));

  imlru_disp_model imlru_disp_model_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_i(wb_o),
    .drain_load_i(drain_load), .drain_len_i(drain_len), .pipe_empty_o(pipe_empty_i));

  always #20 mclk_i = ~mclk_i;

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Bit 32 carries the signed overflow of the operation
  function automatic logic [32:0] calc(imlru_pkg::imlru_issue_t x);
    logic [63:0] p;
    logic [31:0] r;
    logic v;
    v = 1'b0;
    r = 32'h0;
    case (x.op)
      imlru_pkg::OP_MUL_LOW_IMM: r = x.source_a_gpr * {{16{x.imm[15]}}, x.imm};
      imlru_pkg::OP_MUL_LOW_WORD: begin
        p = $signed(x.source_a_gpr) * $signed(x.source_b_gpr);
        r = p[31:0];
        v = (p[63:31] != {33{p[31]}});
      end
      imlru_pkg::OP_NOT_AND: r = ~(x.source_s_gpr & x.source_b_gpr);
      imlru_pkg::OP_TWOS_COMPLEMENT: begin
        r = ~x.source_a_gpr + 32'h1;
        v = (x.source_a_gpr == imlru_pkg::MOST_NEG);
      end
      imlru_pkg::OP_NOT_OR: r = ~(x.source_s_gpr | x.source_b_gpr);
      imlru_pkg::OP_OR_REG: r = x.source_s_gpr | x.source_b_gpr;
      imlru_pkg::OP_OR_INVERTED: r = x.source_s_gpr | ~x.source_b_gpr;
      imlru_pkg::OP_OR_IMM: r = x.source_s_gpr | {16'h0, x.imm};
      imlru_pkg::OP_OR_UPPER_IMM: r = x.source_s_gpr | {x.imm, 16'h0};
      default: r = 32'h0;
    endcase
    return {v, r};
  endfunction : calc

  // Issue valid is held by the caller, so consecutive calls go back to back
  task automatic step(input imlru_pkg::imlru_issue_t x);
    logic [32:0] e;
    issue_i = x;
    @(posedge mclk_i);
    #1;
    e = calc(x);
    if (x.overflow_enable_bit && (x.op == imlru_pkg::OP_MUL_LOW_WORD || x.op == imlru_pkg::OP_TWOS_COMPLEMENT)) begin
      ov_m = e[32];
      so_m = so_m | e[32];
    end
    if (pend) check(imlru_disp_model_inst.gpr_ff[pd], pv);
    check(wb_o.en, 1'b1);
    check(wb_o.dest_idx, x.dest_idx);
    check(wb_o.data, e[31:0]);
    check(overflow_o, ov_m);
    check(summary_overflow_o, so_m);
    check(cr0_we_o, x.record_bit);
    if (x.record_bit) check(cr0_o, {e[31], ~e[31] & (|e[31:0]), ~(|e[31:0]), so_m});
    pend = 1'b1;
    pd = x.dest_idx;
    pv = e[31:0];
  endtask : step

  task automatic put(input int sel, input logic [31:0] d);
    @(posedge mclk_i);
    #1;
    state_wdata_i = d;
    msr_we_i = (sel == 0);
    saved_return_address_we_i = (sel == 1);
    saved_machine_state_we_i = (sel == 2);
    @(posedge mclk_i);
    #1;
    msr_we_i = 1'b0;
    saved_return_address_we_i = 1'b0;
    saved_machine_state_we_i = 1'b0;
  endtask : put

  // The drain is loaded one edge ahead so the return sees a busy pipe when taken
  task automatic ret(input logic [3:0] len, input logic [2:0] exp);
    int n;
    @(posedge mclk_i);
    #1;
    drain_load = 1'b1;
    drain_len = len;
    @(posedge mclk_i);
    #1;
    drain_load = 1'b0;
    issue_i = '0;
    issue_i.op = imlru_pkg::OP_RETURN_FROM_INTERRUPT;
    issue_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
    issue_valid_i = 1'b0;
    if (len != 4'h0) check(issue_ready_o, 1'b0);
    for (n = 0; n < 20; n++) begin
      if (redirect_o | exc_take_o | priv_exc_o) break;
      @(posedge mclk_i);
      #1;
    end
    if (n == 20) begin
      miscompares++;
      wrap_up();
    end
    check(n, len);
    check({redirect_o, exc_take_o, priv_exc_o}, exp);
  endtask : ret

  initial begin
    void'($urandom(32'hab20));
    repeat (8) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    check(issue_ready_o, 1'b1);
    check(msr_o, 32'h0);
    check(wb_o.en, 1'b0);
    issue_valid_i = 1'b1;
    u = '0;
    u.dest_idx = 5'h3;
    u.overflow_enable_bit = 1'b1;
    u.record_bit = 1'b1;
    u.op = imlru_pkg::OP_TWOS_COMPLEMENT;
    u.source_a_gpr = imlru_pkg::MOST_NEG;
    step(u);
    u.op = imlru_pkg::OP_MUL_LOW_WORD;
    u.source_a_gpr = 32'h0001_0000;
    u.source_b_gpr = 32'h0001_0000;
    step(u);
    u.op = imlru_pkg::OP_MUL_LOW_IMM;
    u.source_a_gpr = 32'hffff_fffd;
    u.imm = 16'h8001;
    step(u);
    repeat (80) begin
      u.op = imlru_pkg::imlru_op_t'($urandom % 9);
      u.source_a_gpr = ($urandom % 5 == 0) ? imlru_pkg::MOST_NEG : $urandom;
      u.source_b_gpr = ($urandom % 6 == 0) ? 32'hffff_ffff : $urandom;
      u.source_s_gpr = $urandom;
      u.source_s_idx = 5'($urandom);
      u.dest_idx = 5'($urandom % 31 + 1);
      u.imm = 16'($urandom);
      u.overflow_enable_bit = 1'($urandom);
      u.record_bit = 1'($urandom);
      step(u);
    end
    // Undefined operation code writes back zero, which must read as equal
    u.op = imlru_pkg::imlru_op_t'(4'hf);
    u.record_bit = 1'b1;
    step(u);
    u = '0;
    u.op = imlru_pkg::OP_OR_IMM;
    issue_i = u;
    @(posedge mclk_i);
    #1;
    issue_valid_i = 1'b0;
    check(wb_o.en, 1'b0);
    check(cr0_we_o, 1'b0);
    check(imlru_disp_model_inst.gpr_ff[pd], pv);
    check(overflow_o, ov_m);
    xer_clear_i = 1'b1;
    @(posedge mclk_i);
    #1;
    xer_clear_i = 1'b0;
    check({overflow_o, summary_overflow_o}, 32'h0);
    put(2, 32'hdead_3a5c);
    check(saved_machine_state_o, 32'hdead_3a5c);
    put(1, 32'h1234_5677);
    pending_exc_i = 4'ha;
    ret(4'h3, 3'h4);
    check(msr_o, 32'h0000_3a5c);
    check(fetch_addr_o, 32'h1234_5674);
    put(2, 32'h0000_8123);
    pending_exc_i = 4'h6;
    ret(4'h0, 3'h2);
    check(exc_idx_o, 32'h1);
    check(saved_return_address_o, 32'h1234_5674);
    check(msr_o, 32'h0000_8123);
    put(0, 32'h0000_4000);
    ret(4'h0, 3'h1);
    check(msr_o, 32'h0000_4000);
    // Reset in mid-run must bring back supervisor state and accept work at once
    sys_rst_i = 1'b1;
    @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    ov_m = 1'b0;
    so_m = 1'b0;
    check(msr_o, 32'h0);
    check(issue_ready_o, 1'b1);
    u = '0;
    u.op = imlru_pkg::OP_OR_REG;
    u.dest_idx = 5'h1;
    u.source_s_gpr = 32'h8f0f_0000;
    u.source_b_gpr = 32'h0000_00f0;
    u.overflow_enable_bit = 1'b1;
    u.record_bit = 1'b1;
    issue_valid_i = 1'b1;
    step(u);
    issue_valid_i = 1'b0;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
